// ===== hdl/rom_tag_miller_transmitter.sv
// How it works
// - An 82-bit fixed frame: reserved, name, customer, serial, check and framing bits.
// - Bits leave by index from 0; fields MSB first, check LSB first at 65.
// - The nine reserved bits default to 00B hex.
// - The 10-bit name code is fixed at build time.
// - The 13-bit customer code is fixed at build time.
// - The 32-bit serial code is set per instance at build time.
// - The check register clears when the stop bit starts.
// - The check value covers only the 64 data bits.
// - Start bit is one, stop bit is zero.
// - After power-up the modulator stays on 64 bit periods, then frames start.
// - Supply loss returns to initialising with the modulator on.
// - The serial bit stream is Miller coded straight onto the modulator.
// - Bit period is the carrier clock divided by a build factor, 512 standard.
// - The bit clock steps the address, the encoder and the output.
// - Frames repeat endlessly, each followed by a 9-bit pause.
// - The modulator is held off during the whole pause.
// - The stop bit level follows the coding of the bit before it.
// - The start bit gives half a period off; low means off.
`timescale 1ns/1ps
module rom_tag_miller_transmitter
  import tag_pkg::*;
#(
  parameter int                DIV_FACTOR    = DIV_DEFAULT,
  parameter logic [RSV_W-1:0]  RESERVED      = RSV_DEFAULT,
  parameter logic [NAME_W-1:0] NAME_CODE     = NAME_DEFAULT,
  parameter logic [CUST_W-1:0] CUSTOMER_CODE = CUST_DEFAULT,
  parameter logic [SER_W-1:0]  SERIAL_CODE   = SER_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        supply_ok,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             modulator_on
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  localparam int               DIV_W    = $clog2(DIV_FACTOR);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_FACTOR - 1);
  localparam logic [DIV_W-1:0] DIV_MID  = DIV_W'(DIV_FACTOR / 2 - 1);

  logic             sup_meta_q;
  logic             sup_sync_q;
  logic             run_en_q;
  logic             active;
  logic [DIV_W-1:0] div_cnt_q;
  logic             bit_end;
  logic             bit_mid;
  tx_state_t        state_q;
  tx_state_t        state_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] nxt_idx;
  logic             rom_bit;
  logic [CRC_W-1:0] crc_q;
  logic             nxt_bit;
  logic             cur_bit_q;
  logic             level_q;
  logic             crc_clear;
  logic             crc_shift;
  logic [CRC_W-1:0] crc_last_q;
  logic [15:0]      frames_q;
  tx_status_t       status;
  logic             setup;
  logic             access;
  logic             mapped;
  logic [31:0]      rd_data;

  // ------------------------------------------------------------------
  // Supply level and enable
  // ------------------------------------------------------------------

  // Two-stage synchroniser for the supply detector pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_meta_q <= 1'b0;
      sup_sync_q <= 1'b0;
    end else begin
      sup_meta_q <= supply_ok;
      sup_sync_q <= sup_meta_q;
    end
  end

  // Running needs both supply and the software enable
  assign active = sup_sync_q & run_en_q;

  // ------------------------------------------------------------------
  // Bit clock divider
  // ------------------------------------------------------------------

  // Counter stands in for the toggle chain; held at zero while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
    end else if (!active) begin
      div_cnt_q <= '0;
    end else if (div_cnt_q == DIV_LAST) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  assign bit_end = active && (div_cnt_q == DIV_LAST);
  assign bit_mid = active && (div_cnt_q == DIV_MID);

  // ------------------------------------------------------------------
  // Sequencer: init, frame, pause
  // ------------------------------------------------------------------

  // Next bit position; init always aims at the start bit
  always_comb begin
    if (state_q == ST_INIT || idx_q == IDX_LAST) begin
      nxt_idx = IDX_START;
    end else begin
      nxt_idx = idx_q + 1'b1;
    end
  end

  // State change at each bit boundary
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_INIT: begin
        if (idx_q == INIT_LAST) begin
          state_d = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (idx_q == IDX_STOP) begin
          state_d = ST_PAUSE;
        end
      end
      ST_PAUSE: begin
        if (idx_q == IDX_LAST) begin
          state_d = ST_FRAME;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
  end

  // State register; supply loss forces init at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_INIT;
    end else if (!active) begin
      state_q <= ST_INIT;
    end else if (bit_end) begin
      state_q <= state_d;
    end
  end

  // Bit index, also counts the 64 init periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= '0;
    end else if (!active) begin
      idx_q <= '0;
    end else if (bit_end) begin
      if (state_q == ST_INIT && idx_q != INIT_LAST) begin
        idx_q <= idx_q + 1'b1;
      end else begin
        idx_q <= nxt_idx;
      end
    end
  end

  // ------------------------------------------------------------------
  // Frame source: fused memory and check generator
  // ------------------------------------------------------------------

  // Memory is addressed one bit ahead so data is ready at the boundary
  fused_rom #(
    .RESERVED      (RESERVED),
    .NAME_CODE     (NAME_CODE),
    .CUSTOMER_CODE (CUSTOMER_CODE),
    .SERIAL_CODE   (SERIAL_CODE)
  ) u_rom (
    .pclk    (pclk),
    .presetn (presetn),
    .addr    (nxt_idx),
    .bit_q   (rom_bit)
  );

  // Check register fed with data bits as they start, cleared at stop
  assign crc_shift = bit_end && state_q != ST_INIT &&
                     nxt_idx >= IDX_DATA_FIRST && nxt_idx <= IDX_DATA_LAST;
  assign crc_clear = !active || (bit_end && state_q == ST_FRAME && nxt_idx == IDX_STOP);

  crc_serial u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (crc_clear),
    .shift   (crc_shift),
    .din     (rom_bit),
    .crc_q   (crc_q)
  );

  // Check field goes out least significant bit first
  always_comb begin
    if (nxt_idx >= IDX_CRC_FIRST && nxt_idx <= IDX_CRC_LAST) begin
      nxt_bit = crc_q[4'(nxt_idx - IDX_CRC_FIRST)];
    end else begin
      nxt_bit = rom_bit;
    end
  end

  // Current NRZ bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_bit_q <= 1'b0;
    end else if (bit_end) begin
      cur_bit_q <= nxt_bit;
    end
  end

  // ------------------------------------------------------------------
  // Miller encoder and modulator
  // ------------------------------------------------------------------

  // High means switch on; init holds it on, pause holds it off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b1;
    end else if (!active) begin
      level_q <= 1'b1;
    end else if (bit_end) begin
      if (state_d == ST_INIT) begin
        level_q <= 1'b1;
      end else if (state_d == ST_PAUSE) begin
        level_q <= 1'b0;
      end else if (nxt_idx == IDX_START) begin
        level_q <= 1'b0;
      end else if (!cur_bit_q && !nxt_bit) begin
        level_q <= ~level_q;
      end
    end else if (bit_mid && state_q == ST_FRAME && cur_bit_q) begin
      level_q <= ~level_q;
    end
  end

  assign modulator_on = level_q;

  // ------------------------------------------------------------------
  // Frame bookkeeping
  // ------------------------------------------------------------------

  // Capture the finished check value and count frames at each stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_last_q <= CRC_INIT;
      frames_q   <= 16'h0000;
    end else if (bit_end && state_q == ST_FRAME && nxt_idx == IDX_STOP) begin
      crc_last_q <= crc_q;
      frames_q   <= frames_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign status = '{supply: sup_sync_q, modulator: level_q, idx: idx_q, state: state_q};
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_CRC_LAST) || (paddr == OFS_FRAMES);

  // Read mux, zeros above each field
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:     rd_data = {31'h0000_0000, run_en_q};
      OFS_STATUS:   rd_data = {21'h00_0000, status};
      OFS_CRC_LAST: rd_data = {16'h0000, crc_last_q};
      OFS_FRAMES:   rd_data = {16'h0000, frames_q};
      default:      rd_data = 32'h0000_0000;
    endcase
  end

  // Answer one cycle into the access phase, data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= setup & ~mapped;
    end
  end

  // Control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_en_q <= RUN_EN_RST;
    end else if (access && pwrite && paddr == OFS_CTRL) begin
      run_en_q <= pwdata[0];
    end
  end

endmodule : rom_tag_miller_transmitter

// ===== pkg/tag_pkg.sv
package tag_pkg;

  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int             IDX_W          = 7;
  localparam int             FRAME_BITS     = 82;
  localparam int             PAUSE_BITS     = 9;
  localparam logic [IDX_W-1:0] IDX_START      = 7'h00;
  localparam logic [IDX_W-1:0] IDX_DATA_FIRST = 7'h01;
  localparam logic [IDX_W-1:0] IDX_DATA_LAST  = 7'h40;  // 64
  localparam logic [IDX_W-1:0] IDX_CRC_FIRST  = 7'h41;  // 65
  localparam logic [IDX_W-1:0] IDX_CRC_LAST   = 7'h50;  // 80
  localparam logic [IDX_W-1:0] IDX_STOP       = 7'h51;  // 81
  localparam logic [IDX_W-1:0] IDX_LAST       = 7'h5A;  // 90, last pause bit
  localparam logic [IDX_W-1:0] INIT_LAST      = 7'h3F;  // 64 init bit periods
  localparam logic             START_VAL      = 1'b1;
  localparam logic             STOP_VAL       = 1'b0;

  // ------------------------------------------------------------------
  // Fused field widths and defaults
  // ------------------------------------------------------------------
  localparam int             RSV_W          = 9;
  localparam int             NAME_W         = 10;
  localparam int             CUST_W         = 13;
  localparam int             SER_W          = 32;
  localparam int             DATA_W         = 64;
  localparam logic [RSV_W-1:0]  RSV_DEFAULT   = 9'h00B;
  localparam logic [NAME_W-1:0] NAME_DEFAULT  = 10'h2A5;      // Arbitrary value
  localparam logic [CUST_W-1:0] CUST_DEFAULT  = 13'h0A5A;     // Arbitrary value
  localparam logic [SER_W-1:0]  SER_DEFAULT   = 32'h1234_5678; // Arbitrary value

  // ------------------------------------------------------------------
  // Check code and bit clock
  // ------------------------------------------------------------------
  localparam int             CRC_W          = 16;
  localparam logic [CRC_W-1:0] CRC_POLY      = 16'h1021;
  localparam logic [CRC_W-1:0] CRC_INIT      = 16'h0000;
  localparam int             DIV_DEFAULT    = 512;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [31:0]    OFS_CTRL       = 32'h0000_0000;
  localparam logic [31:0]    OFS_STATUS     = 32'h0000_0004;
  localparam logic [31:0]    OFS_CRC_LAST   = 32'h0000_0008;
  localparam logic [31:0]    OFS_FRAMES     = 32'h0000_000C;
  localparam logic           RUN_EN_RST     = 1'b1;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INIT  = 2'b00,
    ST_FRAME = 2'b01,
    ST_PAUSE = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic             supply;
    logic             modulator;
    logic [IDX_W-1:0] idx;
    tx_state_t        state;
  } tx_status_t;

endpackage : tag_pkg

// ===== hdl/fused_rom.sv
`timescale 1ns/1ps
module fused_rom
  import tag_pkg::*;
#(
  parameter logic [RSV_W-1:0]  RESERVED      = RSV_DEFAULT,
  parameter logic [NAME_W-1:0] NAME_CODE     = NAME_DEFAULT,
  parameter logic [CUST_W-1:0] CUSTOMER_CODE = CUST_DEFAULT,
  parameter logic [SER_W-1:0]  SERIAL_CODE   = SER_DEFAULT
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [IDX_W-1:0] addr,
  output logic                  bit_q
);

  // Data fields in send order, most significant bit leaves first
  localparam logic [DATA_W-1:0] DATA_WORD = {RESERVED, NAME_CODE, CUSTOMER_CODE, SERIAL_CODE};

  logic bit_d;

  // Frame image: framing bits fixed, check field filled by the generator
  always_comb begin
    bit_d = 1'b0;
    if (addr == IDX_START) begin
      bit_d = START_VAL;
    end else if (addr >= IDX_DATA_FIRST && addr <= IDX_DATA_LAST) begin
      bit_d = DATA_WORD[6'(IDX_DATA_LAST - addr)];
    end else if (addr == IDX_STOP) begin
      bit_d = STOP_VAL;
    end
  end

  // Registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end

endmodule : fused_rom

// ===== hdl/crc_serial.sv
`timescale 1ns/1ps
module crc_serial
  import tag_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             shift,
  input  wire logic             din,
  output logic [CRC_W-1:0]      crc_q
);

  logic feedback;

  assign feedback = crc_q[CRC_W-1] ^ din;

  // Serial shift register, clear wins over shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_q <= CRC_INIT;
    end else if (clear) begin
      crc_q <= CRC_INIT;
    end else if (shift) begin
      crc_q <= {crc_q[CRC_W-2:0], 1'b0} ^ (feedback ? CRC_POLY : CRC_INIT);
    end
  end

endmodule : crc_serial

// ===== tb/tx_checker_properties.sv
`timescale 1ns/1ps
module tx_checker
  import tag_pkg::*;
#(
  parameter int DIV_FACTOR = DIV_DEFAULT
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        supply_ok,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        modulator_on
);
  localparam int INIT_CYC = 64 * DIV_FACTOR;
  localparam int SAT      = INIT_CYC + 64;
  logic [15:0] since_q;
  logic [15:0] gap_q;
  logic [15:0] low_q;
  logic [15:0] high_q;
  logic        ctrl_wr;

  // Cycles since supply return or a run control write
  assign ctrl_wr = psel && penable && pready && pwrite && (paddr == OFS_CTRL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= '0;
    end else if (!supply_ok || ctrl_wr) begin
      since_q <= '0;
    end else if (since_q < 16'(SAT)) begin
      since_q <= since_q + 16'h0001;
    end
  end

  // Run lengths and spacing of modulator edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q  <= '0;
      high_q <= '0;
      gap_q  <= '0;
    end else begin
      low_q  <= modulator_on ? 16'h0000 : low_q + 16'h0001;
      high_q <= modulator_on ? high_q + 16'h0001 : 16'h0000;
      gap_q  <= $changed(modulator_on) ? 16'h0001 : gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SETUP_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_UNMAPPED: assert property (psel && !penable && paddr > OFS_FRAMES |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (psel && !penable && paddr <= OFS_FRAMES && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped access refused");
  AST_IDLE_QUIET: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
  AST_SUPPLY_LOSS: assert property (!supply_ok [*5] |-> modulator_on)
    else $error("modulator off without supply");
  // A supply dip takes two cycles to force the switch on, a stop takes one
  AST_INIT_ON: assert property (since_q >= 16'h0002 && since_q < 16'(INIT_CYC) |-> modulator_on)
    else $error("initialisation cut short");
  AST_INIT_END: assert property (since_q == 16'(INIT_CYC) |-> ##[0:16] !modulator_on)
    else $error("frame did not start");
  AST_HALF_GRID: assert property ($changed(modulator_on) && gap_q <= 16'(4 * DIV_FACTOR) && since_q > 16'd8
    |-> gap_q % 16'(DIV_FACTOR / 2) == 16'h0)
    else $error("edge off the half-bit grid");
  AST_OFF_BOUND: assert property (low_q <= 16'(11 * DIV_FACTOR))
    else $error("off time too long");
  AST_ON_BOUND: assert property (since_q == 16'(SAT) |-> high_q <= 16'(2 * DIV_FACTOR))
    else $error("on time too long in frame");

  cover property (pready && pslverr);
  cover property (since_q == 16'(INIT_CYC));
  cover property (low_q == 16'(9 * DIV_FACTOR));
  cover property ($fell(supply_ok));
endmodule : tx_checker

bind rom_tag_miller_transmitter tx_checker #(.DIV_FACTOR(DIV_FACTOR)) chk_u (
  .pclk(pclk), .presetn(presetn), .supply_ok(supply_ok), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .modulator_on(modulator_on)
);

// ===== tb/miller_reader.sv
`timescale 1ns/1ps
module miller_reader #(
  parameter int DIV = 8
) (
  input wire logic pclk,
  input wire logic modulator_on
);
  // Lock onto the first off edge after initialisation
  task automatic align();
    @(negedge modulator_on);
  endtask : align

  // Decode one frame and pause from half-bit samples
  task automatic get_cycle(output logic [90:0] bits, output int bad);
    logic        h1;
    logic        h2;
    logic        p2;
    logic [15:0] crc;
    bad = 0;
    p2  = 1'b0;
    crc = 16'h0000;
    for (int i = 0; i < 91; i++) begin
      repeat (DIV / 4) @(posedge pclk);
      h1 = modulator_on;
      repeat (DIV / 2) @(posedge pclk);
      h2 = modulator_on;
      repeat (DIV / 4) @(posedge pclk);
      bits[i] = (i < 82) ? (h1 ^ h2) : (h1 | h2);
      if (i == 0 && h1 !== 1'b0) bad++;
      if (i > 0 && i < 82 && ((h1 != p2) !== (!bits[i] && !bits[i-1]))) bad++;
      if (i >= 1 && i <= 64) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ bits[i]) ? 16'h1021 : 16'h0000);
      if (i >= 65 && i <= 80 && bits[i] !== crc[i-65]) bad++;
      p2 = h2;
    end
  endtask : get_cycle
endmodule : miller_reader

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
  import tag_pkg::*;
;
  localparam int          DIV  = 8;
  localparam logic [9:0]  NAME = 10'h155;       // Arbitrary value
  localparam logic [12:0] CUST = 13'h1ACE;      // Arbitrary value
  localparam logic [31:0] SER  = 32'hC0DE_F00D; // Arbitrary value
  logic        pclk, presetn, supply_ok, psel, penable, pwrite, pready, pslverr, modulator_on;
  logic [31:0] paddr, pwdata, prdata;
  logic [81:0] exp_frame;
  logic [15:0] exp_crc;
  int          n_mismatch, comparisons;

  rom_tag_miller_transmitter #(.DIV_FACTOR(DIV), .NAME_CODE(NAME), .CUSTOMER_CODE(CUST), .SERIAL_CODE(SER)) dut_u (
    .pclk(pclk), .presetn(presetn), .supply_ok(supply_ok), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modulator_on(modulator_on)
  );
  miller_reader #(.DIV(DIV)) reader_u (.pclk(pclk), .modulator_on(modulator_on));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic chk(input logic [90:0] got, input logic [90:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Expected frame: start, data MSB first, check LSB first, stop
  function automatic void build_expect();
    logic [63:0] d;
    d = {RSV_DEFAULT, NAME, CUST, SER};
    exp_crc = 16'h0000;
    exp_frame = '0;
    exp_frame[0] = 1'b1;
    for (int k = 0; k < 64; k++) begin
      exp_crc = {exp_crc[14:0], 1'b0} ^ ((exp_crc[15] ^ d[63-k]) ? 16'h1021 : 16'h0000);
      exp_frame[1+k] = d[63-k];
    end
    for (int k = 0; k < 16; k++) exp_frame[65+k] = exp_crc[k];
  endfunction : build_expect

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(91'(n < 16), 91'd1, "apb wait");
  endtask : apb

  task automatic wait_init(input string what);
    longint t0;
    longint cyc;
    t0 = $time;
    reader_u.align();
    cyc = ($time - t0) / 25;
    chk(91'(cyc >= 64 * DIV && cyc <= 64 * DIV + 6), 91'd1, what);
  endtask : wait_init

  task automatic check_cycles(input int n);
    logic [90:0] bits;
    int          bad;
    repeat (n) begin
      reader_u.get_cycle(bits, bad);
      chk(bits, {9'h000, exp_frame}, "frame bits");
      chk(91'(bad), 91'd0, "coding");
    end
  endtask : check_cycles

  task automatic test_power_up();
    wait_init("power-up init");
    check_cycles(2);
    $display("test_power_up done");
  endtask : test_power_up

  task automatic test_supply_loss();
    repeat (300) @(posedge pclk);
    supply_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(91'(modulator_on), 91'd1, "on after loss");
    repeat (20) @(posedge pclk);
    chk(91'(modulator_on), 91'd1, "held on");
    supply_ok <= 1'b1;
    wait_init("re-init");
    check_cycles(1);
    $display("test_supply_loss done");
  endtask : test_supply_loss

  task automatic test_registers();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, OFS_CTRL, 32'h0, rd, er);
    chk(91'({er, rd}), 91'h1, "ctrl reset");
    apb(1'b0, OFS_CRC_LAST, 32'h0, rd, er);
    chk(91'({er, rd}), 91'(exp_crc), "check value");
    // Two frames before the supply dip, one after it
    apb(1'b0, OFS_FRAMES, 32'h0, rd, er);
    chk(91'({er, rd}), 91'd3, "frame count");
    // Supply seen and sequencer in the frame state early in a frame
    apb(1'b0, OFS_STATUS, 32'h0, rd, er);
    chk(91'({er, rd[10], rd[1:0]}), 91'h5, "status supply and state");
    apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF, rd, er);
    chk(91'(er), 91'h0, "read-only write");
    apb(1'b0, 32'h0000_0010, 32'h0, rd, er);
    chk(91'({er, rd}), 91'h1_0000_0000, "unmapped");
    apb(1'b1, OFS_CTRL, 32'h0, rd, er);
    repeat (20) @(posedge pclk);
    chk(91'(modulator_on), 91'd1, "stopped on");
    apb(1'b1, OFS_CTRL, 32'h1, rd, er);
    wait_init("restart");
    check_cycles(1);
    $display("test_registers done");
  endtask : test_registers

  // Main sequence
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    presetn = 1'b0;
    supply_ok = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    build_expect();
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_power_up();
    test_supply_loss();
    test_registers();
    conclude();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
endmodule : tb
